// File: design/dual_clock_fifo_flag_logic.sv
// Dual-clock 18-bit buffer with empty/full and programmable flags.
// Assumes write side on sys_clk, read side on rd_clk, both free-running.
`timescale 1ns/1ps
module dual_clock_fifo_flag_logic
(
  // Write side clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Read side clock
  input wire logic rd_clk,
  // Write port
  input wire logic wr_en_n,
  input wire logic [17:0] wr_data,
  output logic wr_ready,
  // Read port
  input wire logic rd_en_n,
  input wire logic out_drive_off,
  output logic [17:0] rd_data,
  output logic [17:0] rd_data_oe,
  // Configuration
  input wire logic [5:0] empty_offset,
  input wire logic [5:0] full_offset,
  input wire logic sync_flag_select,
  input wire logic retransmit,
  // Status
  output logic full_flag_n,
  output logic almost_full_flag_n,
  output logic empty_flag_n,
  output logic almost_empty_flag_n,
  output logic wr_expand_out,
  output logic rd_expand_out
);
  localparam int AW = fifo_flag_pkg::ADDR_W;
  localparam int PW = fifo_flag_pkg::PTR_W;
  localparam logic [PW-1:0] DEPTH_P = PW'(fifo_flag_pkg::DEPTH);

  logic [17:0] mem [fifo_flag_pkg::DEPTH];

  // Input skid buffer on the write side
  logic sk_valid;
  logic [17:0] sk_data;
  wire sk_take;
  wire in_ready;
  skid_fifo #(.WIDTH(18), .DEPTH(fifo_flag_pkg::SKID_DEPTH)) u_skid (
    .clk(sys_clk),
    .srst(srst),
    .in_valid(!wr_en_n),
    .in_ready(in_ready),
    .in_data(wr_data),
    .out_valid(sk_valid),
    .out_ready(sk_take),
    .out_data(sk_data)
  );

  // Read-domain reset, three-stage with agreement
  logic [2:0] rrst_sync;
  logic rrst;
  always_ff @(posedge rd_clk)
  begin
    rrst_sync <= {rrst_sync[1:0], srst};
    if (rrst_sync[2] == rrst_sync[1])
      rrst <= rrst_sync[2];
  end

  // Retransmit: level synchronised into write domain, pulses the pointers
  logic [2:0] rt_sync;
  logic rt_level;
  logic rt_prev;
  always_ff @(posedge sys_clk)
  begin
    rt_sync <= {rt_sync[1:0], retransmit};
    if (srst)
    begin
      rt_level <= 1'b0;
      rt_prev <= 1'b0;
    end
    else
    begin
      if (rt_sync[2] == rt_sync[1])
        rt_level <= rt_sync[2];
      rt_prev <= rt_level;
    end
  end
  wire rt_start = rt_level && !rt_prev;

  fifo_flag_pkg::rt_state_t rt_state;
  fifo_flag_pkg::rt_state_t next_rt_state;
  logic [3:0] rt_cnt;
  always_comb
  begin
    next_rt_state = rt_state;
    case (rt_state)
      fifo_flag_pkg::RT_IDLE:
        if (rt_start)
          next_rt_state = fifo_flag_pkg::RT_HOLD;
      fifo_flag_pkg::RT_HOLD:
        if (rt_cnt == 4'(fifo_flag_pkg::RTR_CYCLES))
          next_rt_state = fifo_flag_pkg::RT_SETTLE;
      fifo_flag_pkg::RT_SETTLE:
        next_rt_state = fifo_flag_pkg::RT_IDLE;
      default:
        next_rt_state = fifo_flag_pkg::RT_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      rt_state <= fifo_flag_pkg::RT_IDLE;
      rt_cnt <= 4'h0;
    end
    else
    begin
      rt_state <= next_rt_state;
      rt_cnt <= (rt_state == fifo_flag_pkg::RT_HOLD) ? rt_cnt + 4'h1 : 4'h0;
    end
  end
  wire rt_busy = (rt_state != fifo_flag_pkg::RT_IDLE);

  // Retransmit request crosses to read side as a toggle
  logic rt_tog;
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      rt_tog <= 1'b0;
    else if (rt_start)
      rt_tog <= !rt_tog;
  end
  logic [2:0] rt_tog_sync;
  logic rt_tog_seen;
  always_ff @(posedge rd_clk)
  begin
    rt_tog_sync <= {rt_tog_sync[1:0], rt_tog};
    if (rrst)
      rt_tog_seen <= 1'b0;
    else if (rt_tog_sync[2] == rt_tog_sync[1])
      rt_tog_seen <= rt_tog_sync[2];
  end
  logic rt_tog_last;
  always_ff @(posedge rd_clk)
  begin
    if (rrst)
      rt_tog_last <= 1'b0;
    else
      rt_tog_last <= rt_tog_seen;
  end
  wire rt_rd = rt_tog_seen != rt_tog_last;

  // Write pointer and write-side flags
  logic [PW-1:0] wptr;
  logic [PW-1:0] wptr_gray;
  logic [PW-1:0] rptr_gray_s1;
  logic [PW-1:0] rptr_gray_s2;
  logic [PW-1:0] rptr_w;
  logic [PW-1:0] rptr_gray;
  wire [PW-1:0] wcount = wptr - rptr_w;
  wire fifo_full = (wcount == DEPTH_P);
  assign sk_take = !fifo_full && !rt_busy;
  wire do_write = sk_valid && sk_take;
  wire [PW-1:0] next_wptr = wptr + PW'(do_write);
  wire [PW-1:0] next_wcount = next_wptr - rptr_w;
  wire [PW-1:0] af_level = DEPTH_P - PW'(full_offset) + 7'h01;
  wire af_now = !(next_wcount >= af_level);

  always_ff @(posedge sys_clk)
  begin
    if (do_write)
      mem[wptr[AW-1:0]] <= sk_data;
  end

  always_ff @(posedge sys_clk)
  begin
    rptr_gray_s1 <= rptr_gray;
    rptr_gray_s2 <= rptr_gray_s1;
  end
  always_comb
  begin
    rptr_w[PW-1] = rptr_gray_s2[PW-1];
    for (int i = PW - 2; i >= 0; i--)
      rptr_w[i] = rptr_w[i+1] ^ rptr_gray_s2[i];
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst || rt_start)
    begin
      wptr <= fifo_flag_pkg::RESET_PTR;
      wptr_gray <= fifo_flag_pkg::RESET_PTR;
      full_flag_n <= 1'b1;
      almost_full_flag_n <= 1'b1;
      wr_expand_out <= 1'b0;
      wr_ready <= 1'b0;
    end
    else
    begin
      wptr <= next_wptr;
      wptr_gray <= next_wptr ^ (next_wptr >> 1);
      full_flag_n <= !((next_wptr - rptr_w) == DEPTH_P);
      if (!(sync_flag_select && rt_state == fifo_flag_pkg::RT_SETTLE))
        almost_full_flag_n <= af_now;
      wr_expand_out <= do_write && (wptr[AW-1:0] == fifo_flag_pkg::LAST_LOC);
      wr_ready <= in_ready;
    end
  end

  // Read pointer and read-side flags
  logic [PW-1:0] rptr;
  logic [PW-1:0] wptr_gray_s1;
  logic [PW-1:0] wptr_gray_s2;
  logic [PW-1:0] wptr_r;
  always_ff @(posedge rd_clk)
  begin
    wptr_gray_s1 <= wptr_gray;
    wptr_gray_s2 <= wptr_gray_s1;
  end
  always_comb
  begin
    wptr_r[PW-1] = wptr_gray_s2[PW-1];
    for (int i = PW - 2; i >= 0; i--)
      wptr_r[i] = wptr_r[i+1] ^ wptr_gray_s2[i];
  end
  wire fifo_empty = (wptr_r == rptr);
  wire do_read = !rd_en_n && empty_flag_n && !fifo_empty;
  wire [PW-1:0] next_rptr = rptr + PW'(do_read);
  wire [PW-1:0] next_rcount = wptr_r - next_rptr;
  wire ae_now = !(next_rcount <= PW'(empty_offset));

  always_ff @(posedge rd_clk)
  begin
    if (rrst || rt_rd)
    begin
      rptr <= fifo_flag_pkg::RESET_PTR;
      rptr_gray <= fifo_flag_pkg::RESET_PTR;
      empty_flag_n <= 1'b0;
      almost_empty_flag_n <= 1'b0;
      rd_expand_out <= 1'b0;
    end
    else
    begin
      rptr <= next_rptr;
      rptr_gray <= next_rptr ^ (next_rptr >> 1);
      empty_flag_n <= (wptr_r != next_rptr);
      if (!sync_flag_select)
        almost_empty_flag_n <= ae_now;
      else
        almost_empty_flag_n <= !((wptr_r - rptr) <= PW'(empty_offset));
      rd_expand_out <= do_read && (rptr[AW-1:0] == fifo_flag_pkg::LAST_LOC);
    end
  end

  // Output register: head word is loaded on a read request while empty is released
  wire [17:0] head_word = mem[rptr[AW-1:0]];
  always_ff @(posedge rd_clk)
  begin
    if (rrst)
    begin
      rd_data <= fifo_flag_pkg::RESET_DATA;
      rd_data_oe <= {18{1'b0}};
    end
    else
    begin
      if (empty_flag_n && (do_read || !rd_en_n))
        rd_data <= head_word;
      rd_data_oe <= {18{!out_drive_off}};
    end
  end
endmodule // dual_clock_fifo_flag_logic

// File: design/fifo_flag_pkg.sv
// Package for the dual-clock flag buffer: widths, depths, flag layouts.
// Assumes one write domain (sys_clk) and one read domain (rd_clk).
package fifo_flag_pkg;
  localparam int DATA_W = 18;
  localparam int DEPTH = 64;
  localparam int ADDR_W = 6;
  localparam int PTR_W = 7;
  localparam int SYNC_STAGES = 2;
  localparam int SKID_DEPTH = 8;
  localparam int RTR_NS = 40;
  localparam int SYS_CLK_NS = 20;
  localparam int RTR_CYCLES = (RTR_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam logic [PTR_W-1:0] RESET_PTR = 7'h00;
  localparam logic [DATA_W-1:0] RESET_DATA = 18'h00000;
  localparam logic [ADDR_W-1:0] LAST_LOC = 6'h3F;

  typedef struct packed {
    logic empty_flag_n;
    logic almost_empty_flag_n;
  } rd_flags_t;

  typedef struct packed {
    logic full_flag_n;
    logic almost_full_flag_n;
  } wr_flags_t;

  typedef enum logic [2:0] {
    RT_IDLE = 3'b001,
    RT_HOLD = 3'b010,
    RT_SETTLE = 3'b100
  } rt_state_t;
endpackage

// File: design/skid_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
// Assumes both sides share one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module skid_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (cnt < (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end
    else
    begin
      if (push)
        wp <= (wp == AW'(DEPTH - 1)) ? '0 : wp + 1'b1;
      if (pop)
        rp <= (rp == AW'(DEPTH - 1)) ? '0 : rp + 1'b1;
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // skid_fifo

// File: test/fifo_flag_asserts.sv
// Port checker for the dual-clock flag buffer, bound to its top.
// Assumes srst is seen by both clock domains.
`timescale 1ns/1ps
module fifo_flag_asserts
(
  // Clocks and reset
  input wire logic sys_clk,
  input wire logic rd_clk,
  input wire logic srst,
  // Requests
  input wire logic rd_en_n,
  input wire logic out_drive_off,
  input wire logic retransmit,
  // Outputs
  input wire logic [17:0] rd_data,
  input wire logic [17:0] rd_data_oe,
  input wire logic full_flag_n,
  input wire logic almost_full_flag_n,
  input wire logic empty_flag_n,
  input wire logic almost_empty_flag_n,
  input wire logic wr_expand_out,
  input wire logic rd_expand_out
);
  a_wr_reset_vals: assert property (
    @(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> full_flag_n && almost_full_flag_n && !wr_expand_out)
    else $error("write flags not reset");
  a_rd_reset_vals: assert property (
    @(posedge rd_clk) disable iff (srst)
    $fell(srst) |-> !empty_flag_n && !almost_empty_flag_n
      && rd_data == 18'h00000)
    else $error("read side not reset");
  a_oe_off_float: assert property (
    @(posedge rd_clk) disable iff (srst)
    out_drive_off[*3] |-> rd_data_oe == 18'h00000)
    else $error("data driven while off");
  a_wr_exp_pulse: assert property (
    @(posedge sys_clk) disable iff (srst)
    wr_expand_out |=> !wr_expand_out)
    else $error("write expansion pulse too long");
  a_rd_exp_pulse: assert property (
    @(posedge rd_clk) disable iff (srst)
    rd_expand_out |=> !rd_expand_out)
    else $error("read expansion pulse too long");
  a_rd_exp_cause: assert property (
    @(posedge rd_clk) disable iff (srst)
    rd_expand_out |-> $past(!rd_en_n) && $past(empty_flag_n))
    else $error("read expansion without read");
  a_empty_ae_low: assert property (
    @(posedge rd_clk) disable iff (srst)
    (!retransmit && !empty_flag_n)[*4] |-> !almost_empty_flag_n)
    else $error("empty but not almost empty");
  a_full_af_low: assert property (
    @(posedge sys_clk) disable iff (srst)
    (!retransmit && !full_flag_n)[*4] |-> !almost_full_flag_n)
    else $error("full but not almost full");
  c_full: cover property (@(posedge sys_clk) $fell(full_flag_n));
  c_empty_out: cover property (@(posedge rd_clk) $rose(empty_flag_n));
  c_rd_exp: cover property (@(posedge rd_clk) rd_expand_out);
endmodule // fifo_flag_asserts

bind dual_clock_fifo_flag_logic fifo_flag_asserts i_fifo_flag_asserts (
  .sys_clk, .rd_clk, .srst, .rd_en_n, .out_drive_off, .retransmit,
  .rd_data, .rd_data_oe, .full_flag_n, .almost_full_flag_n,
  .empty_flag_n, .almost_empty_flag_n, .wr_expand_out, .rd_expand_out);

// File: test/fifo_consumer.sv
// Consumer model on the read clock: takes words up to a quota.
// Assumes the buffer samples its read enable on rising rd_clk.
`timescale 1ns/1ps
module fifo_consumer
(
  // Read side
  input wire logic rd_clk,
  input wire logic empty_flag_n,
  input wire logic [17:0] rd_data,
  output logic rd_en_n,
  // Bench control
  input wire logic slow,
  input wire logic [15:0] quota,
  output logic got,
  output logic [17:0] word
);
  logic [15:0] taken = 16'h0000;
  initial rd_en_n = 1'b1;
  initial got = 1'b0;
  // Asks even when empty, so ignored reads get exercised
  always @(negedge rd_clk)
    rd_en_n <= !(taken < quota && !(slow && $urandom_range(1)));
  always @(posedge rd_clk)
  begin
    got <= !rd_en_n && empty_flag_n;
    if (!rd_en_n && empty_flag_n)
      taken <= taken + 16'h0001;
  end
  assign word = rd_data;
endmodule // fifo_consumer

// File: test/dual_clock_fifo_flag_logic_tb.sv
// Self-checking bench for the dual-clock flag buffer.
// Assumes the consumer model owns the read enable.
`timescale 1ns/1ps
module dual_clock_fifo_flag_logic_tb;
  logic sys_clk, rd_clk, srst, wr_en_n, wr_ready, rd_en_n, out_drive_off;
  logic [17:0] wr_data, rd_data, rd_data_oe, word;
  logic [5:0] empty_offset, full_offset;
  logic sync_flag_select, retransmit, full_flag_n, almost_full_flag_n;
  logic empty_flag_n, almost_empty_flag_n, wr_expand_out, rd_expand_out;
  logic slow, got;
  logic [15:0] quota;
  logic [17:0] q[$];
  int err_count, checks_done, cyc, wx, rx, rd_total;
  localparam int CAP = fifo_flag_pkg::DEPTH + fifo_flag_pkg::SKID_DEPTH;

  dual_clock_fifo_flag_logic i_dual_clock_fifo_flag_logic (.sys_clk,
    .srst, .rd_clk, .wr_en_n, .wr_data, .wr_ready, .rd_en_n,
    .out_drive_off, .rd_data, .rd_data_oe, .empty_offset, .full_offset,
    .sync_flag_select, .retransmit, .full_flag_n, .almost_full_flag_n,
    .empty_flag_n, .almost_empty_flag_n, .wr_expand_out, .rd_expand_out);
  fifo_consumer i_fifo_consumer (.rd_clk, .empty_flag_n, .rd_data,
    .rd_en_n, .slow, .quota, .got, .word);

  task automatic chk(input string nm, input logic [17:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic fl(input string nm, input logic e, g);
    chk(nm, {17'h00000, e}, {17'h00000, g});
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // Gap after each write keeps wr_ready meaningful
  task automatic put(int k);
    repeat (k)
    begin
      @(negedge sys_clk);
      wr_data = 18'($urandom);
      wr_en_n = 1'b0;
      if (q.size() < CAP)
        q.push_back(wr_data);
      @(negedge sys_clk);
      wr_en_n = 1'b1;
    end
  endtask
  task automatic drain(int s);
    rd_total += q.size() - s;
    quota = 16'(rd_total);
    for (int i = 0; i < 3000 && q.size() > s; i++)
      @(negedge sys_clk);
    tick(20);
  endtask

  always @(negedge rd_clk)
    if (got === 1'b1)
      chk("rd_data", q.size() ? q.pop_front() : 18'hXXXXX, word);
  always @(posedge sys_clk)
  begin
    wx += (wr_expand_out === 1'b1);
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      end_sim();
    end
  end
  always @(posedge rd_clk)
    rx += (rd_expand_out === 1'b1);
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Both clocks run through reset and retransmit
  initial
  begin
    rd_clk = 1'b0;
    #7;
    forever #24 rd_clk = ~rd_clk;
  end

  initial
  begin
    {srst, wr_en_n, retransmit, slow} = 4'hC;
    {wr_data, out_drive_off, sync_flag_select, quota} = '0;
    {empty_offset, full_offset} = 12'h041;
    void'($urandom(32'hF847FD96));
    // Read side needs five of its own edges before its outputs settle
    tick(14);
    chk("rd_data", 18'h00000, rd_data);
    srst = 1'b0;
    tick(2);
    fl("empty", 1'b0, empty_flag_n);
    fl("full", 1'b1, full_flag_n);
    out_drive_off = 1'b1;
    tick(10);
    chk("oe", 18'h00000, rd_data_oe);
    out_drive_off = 1'b0;
    tick(10);
    chk("oe", 18'h3FFFF, rd_data_oe);
    $display("test reset done");
    for (int md = 0; md < 2; md++)
    begin
      sync_flag_select = md[0];
      slow = md[0];
      full_offset = 6'($urandom_range(40, 1));
      empty_offset = 6'($urandom_range(30, 1));
      put(64 - full_offset);
      tick(20);
      fl("empty", 1'b1, empty_flag_n);
      fl("almost_full", 1'b1, almost_full_flag_n);
      put(1);
      tick(20);
      fl("almost_full", 1'b0, almost_full_flag_n);
      put(13 + full_offset);
      tick(20);
      fl("full", 1'b0, full_flag_n);
      fl("wr_ready", 1'b0, wr_ready);
      drain(empty_offset + 1);
      fl("almost_empty", 1'b1, almost_empty_flag_n);
      fl("full", 1'b1, full_flag_n);
      drain(empty_offset);
      fl("almost_empty", 1'b0, almost_empty_flag_n);
      drain(0);
      fl("empty", 1'b0, empty_flag_n);
      $display("test mode %0d done", md);
    end
    chk("wr_expand", 18'd2, 18'(wx));
    chk("rd_expand", 18'd2, 18'(rx));
    put(5);
    tick(20);
    retransmit = 1'b1;
    tick(2);
    retransmit = 1'b0;
    q.delete();
    tick(20);
    fl("empty", 1'b0, empty_flag_n);
    fl("full", 1'b1, full_flag_n);
    fl("almost_empty", 1'b0, almost_empty_flag_n);
    $display("test retransmit done");
    end_sim();
  end
endmodule // dual_clock_fifo_flag_logic_tb
